// File: ssic_consts.svh
`ifndef SSIC_CONSTS_SVH
`define SSIC_CONSTS_SVH
`define SSIC_ADDR_W       20
`define SSIC_LANES        4
`define SSIC_LANE_W       8
`define SSIC_BURST_W      2
`define SSIC_CNT_RESET    2'h0
`endif

// File: ssic_pkg.sv
package ssic_pkg;
    typedef enum logic [1:0] {
        SSIC_DESELECTED,
        SSIC_FIRST,
        SSIC_ACTIVE
    } ssic_state_e;
endpackage

// File: ssic_lane_gate.sv
`timescale 1ns/100ps
`include "ssic_consts.svh"
module ssic_lane_gate #(
    parameter int LANE_W = `SSIC_LANE_W
) (
    input  wire logic              write_go_in,   // Write accepted this edge
    input  wire logic              lane_sel_n_in, // Byte-lane write select, low active
    input  wire logic [LANE_W-1:0] data_in,       // Byte to write
    input  wire logic              parity_in,     // Parity bit of the byte
    output logic                   lane_we_out,   // Lane write strobe
    output logic [LANE_W:0]        word_out       // Parity and data together
);
    assign lane_we_out = write_go_in & ~lane_sel_n_in; // see R02 see R13
    assign word_out    = {parity_in, data_in};
endmodule

// File: ssic_top.sv
// Overview of operation
// R01 - Address captured on rising clock edge
// R02 - Low byte selects write own byte, parity
// R03 - Low write strobe starts write, qualified
// R04 - Load/advance high steps burst counter
// R05 - Load/advance low loads new address
// R06 - Controller loads address after deselect
// R07 - Act only on edges with qualify low
// R08 - Selects one and three active low
// R09 - Select two active high, combined
// R10 - Qualify high holds cycle, keeps selection
// R11 - Strap picks interleaved or linear order
// R12 - Outputs float on write, first, deselect
// R13 - Lane selects ignored unless writing selected
`timescale 1ns/100ps
`include "ssic_consts.svh"
module ssic_top #(
    parameter int ADDR_W  = `SSIC_ADDR_W,
    parameter int LANES   = `SSIC_LANES,
    parameter int LANE_W  = `SSIC_LANE_W
) (
    input  wire logic                      CLK_IN,               // Clock
    input  wire logic                      RESETN_IN,            // Async reset, low active
    input  wire logic [ADDR_W-1:0]         ADDRESS_IN,           // Address incl bits one, zero
    input  wire logic [LANES-1:0]          BYTE_LANE_WRITE_SEL_N_IN, // Lane selects, low active
    input  wire logic                      WRITE_STROBE_N_IN,    // Write strobe, low active
    input  wire logic                      BURST_STEP_OR_FETCH_IN, // High step, low load
    input  wire logic                      CLOCK_QUALIFY_N_IN,   // Clock qualify, low active
    input  wire logic                      CHIP_SELECT_ONE_N_IN, // Select one, low active
    input  wire logic                      CHIP_SELECT_TWO_IN,   // Select two, high active
    input  wire logic                      CHIP_SELECT_THREE_N_IN, // Select three, low active
    input  wire logic                      BURST_ORDER_IN,       // High interleaved, low linear
    input  wire logic [LANES*LANE_W-1:0]   WRITE_DATA_IN,        // Write data
    input  wire logic [LANES-1:0]          PARITY_LANE_IN,       // Write parity per lane
    output logic [ADDR_W-1:0]              ACCESS_ADDR_OUT,      // Current array address
    output logic [LANES-1:0]               LANE_WRITE_OUT,       // Lane write strobes
    output logic [LANES*(LANE_W+1)-1:0]    ARRAY_WDATA_OUT,      // Parity and data per lane
    output logic                           READ_GO_OUT,          // Read access this cycle
    output logic                           SELECTED_OUT,         // Device selected
    output logic                           OUTPUT_FLOAT_OUT      // Data outputs must float
);
    localparam int BW = `SSIC_BURST_W;

    ssic_pkg::ssic_state_e state_r;
    ssic_pkg::ssic_state_e state_nxt;
    logic [ADDR_W-1:0]     base_r;
    logic [BW-1:0]         cnt_r;
    logic                  write_r;
    logic                  order_r;
    logic                  order_taken_r;
    logic [ADDR_W-1:0]     addr_r;
    logic [LANES-1:0]      lane_we_r;
    logic [LANES*(LANE_W+1)-1:0] wdata_r;
    logic                  read_r;
    logic                  sel_r;
    logic                  float_r;

    // Selection, load, step and deselect decode
    wire edge_ok    = ~CLOCK_QUALIFY_N_IN; // see R07 see R10
    wire chip_sel   = ~CHIP_SELECT_ONE_N_IN & ~CHIP_SELECT_THREE_N_IN // see R08
                    & CHIP_SELECT_TWO_IN; // see R09
    wire do_load    = edge_ok & chip_sel & ~BURST_STEP_OR_FETCH_IN; // see R05
    wire do_step    = edge_ok & BURST_STEP_OR_FETCH_IN
                    & (state_r != ssic_pkg::SSIC_DESELECTED); // see R04
    wire do_desel   = edge_ok & ~chip_sel & ~BURST_STEP_OR_FETCH_IN;
    wire write_now  = do_load ? ~WRITE_STROBE_N_IN : write_r; // see R03
    // Burst position for the loaded base, either order
    wire [BW-1:0] cnt_nxt   = do_load ? `SSIC_CNT_RESET : cnt_r + {{(BW-1){1'b0}}, 1'b1};
    wire [ADDR_W-1:0] base_nxt = do_load ? ADDRESS_IN : base_r; // see R01
    wire [BW-1:0] low_lin   = base_nxt[BW-1:0] + cnt_nxt;
    wire [BW-1:0] low_int   = base_nxt[BW-1:0] ^ cnt_nxt;
    wire [BW-1:0] low_sel   = order_r ? low_int : low_lin; // see R11
    wire [ADDR_W-1:0] addr_nxt = {base_nxt[ADDR_W-1:BW], low_sel};
    wire access_go  = do_load | do_step;
    wire write_go   = access_go & write_now; // see R13
    wire [LANES-1:0] lane_we;
    wire [LANES*(LANE_W+1)-1:0] lane_word;

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            ssic_lane_gate #(.LANE_W(LANE_W)) u_lane (
                .write_go_in   (write_go),
                .lane_sel_n_in (BYTE_LANE_WRITE_SEL_N_IN[g]),
                .data_in       (WRITE_DATA_IN[g*LANE_W +: LANE_W]),
                .parity_in     (PARITY_LANE_IN[g]),
                .lane_we_out   (lane_we[g]),
                .word_out      (lane_word[g*(LANE_W+1) +: LANE_W+1])
            );
        end
    endgenerate

    // Next state; a deselect outranks a load
    always_comb begin
        state_nxt = state_r;
        if (do_desel) begin
            state_nxt = ssic_pkg::SSIC_DESELECTED;
        end else if (do_load) begin
            state_nxt = (state_r == ssic_pkg::SSIC_DESELECTED) ?
                        ssic_pkg::SSIC_FIRST : ssic_pkg::SSIC_ACTIVE;
        end else if (do_step) begin
            state_nxt = ssic_pkg::SSIC_ACTIVE;
        end
        case (state_r)
            ssic_pkg::SSIC_DESELECTED: ;
            ssic_pkg::SSIC_FIRST:      ;
            ssic_pkg::SSIC_ACTIVE:     ;
            default: state_nxt = ssic_pkg::SSIC_DESELECTED;
        endcase
    end

    // Strap caught once after reset release
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            order_r       <= 1'b1;
            order_taken_r <= 1'b0;
        end else if (!order_taken_r) begin
            order_r       <= BURST_ORDER_IN; // see R11
            order_taken_r <= 1'b1;
        end
    end

    // State and burst counter move on qualified edges only
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_r <= ssic_pkg::SSIC_DESELECTED;
            base_r  <= '0;
            cnt_r   <= `SSIC_CNT_RESET;
            write_r <= 1'b0;
        end else if (edge_ok) begin // see R07
            state_r <= state_nxt;
            if (access_go) begin
                base_r  <= base_nxt;
                cnt_r   <= cnt_nxt;
                write_r <= write_now;
            end
        end
    end

    // Pulses clear on stalled edges, levels hold
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            addr_r    <= '0;
            lane_we_r <= '0;
            wdata_r   <= '0;
            read_r    <= 1'b0;
            sel_r     <= 1'b0;
            float_r   <= 1'b1;
        end else begin
            lane_we_r <= lane_we;
            read_r    <= access_go & ~write_now;
            if (access_go) begin
                addr_r  <= addr_nxt;
                wdata_r <= lane_word;
            end
            if (edge_ok) begin // see R10
                sel_r   <= state_nxt != ssic_pkg::SSIC_DESELECTED;
                float_r <= (state_nxt != ssic_pkg::SSIC_ACTIVE) | write_now; // see R12
            end
        end
    end

    assign ACCESS_ADDR_OUT  = addr_r;
    assign LANE_WRITE_OUT   = lane_we_r;
    assign ARRAY_WDATA_OUT  = wdata_r;
    assign READ_GO_OUT      = read_r;
    assign SELECTED_OUT     = sel_r;
    assign OUTPUT_FLOAT_OUT = float_r;

    // Checks on the registered outputs
    a_hold_on_qualify: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R10
        CLOCK_QUALIFY_N_IN |=> $stable(SELECTED_OUT) && LANE_WRITE_OUT == '0)
        else $error("qualify high did not hold the cycle");
    a_load_address: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R05
        do_load && !order_r |=> ACCESS_ADDR_OUT == $past(ADDRESS_IN))
        else $error("load did not take address");
    a_step_linear: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R04
        do_step && !order_r ##1 do_step && !order_r
        |=> ACCESS_ADDR_OUT[1:0] == $past(ACCESS_ADDR_OUT[1:0]) + 2'h1)
        else $error("burst step wrong");
    a_select_combine: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R08
        edge_ok && !BURST_STEP_OR_FETCH_IN |=> SELECTED_OUT == $past(chip_sel))
        else $error("selection wrong");
    a_select_two: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R09
        edge_ok && !BURST_STEP_OR_FETCH_IN && !CHIP_SELECT_TWO_IN |=> !SELECTED_OUT)
        else $error("select two low did not deselect");
    a_write_lanes: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R02
        do_load && !WRITE_STROBE_N_IN |=> LANE_WRITE_OUT == ~$past(BYTE_LANE_WRITE_SEL_N_IN))
        else $error("lane writes wrong");
    a_no_write_read: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R13
        do_load && WRITE_STROBE_N_IN |=> LANE_WRITE_OUT == '0 && READ_GO_OUT)
        else $error("write on read cycle");
    a_write_gate: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R03
        LANE_WRITE_OUT != '0 |-> $past(edge_ok))
        else $error("write without qualify");
    a_float_first: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R12
        !SELECTED_OUT ##1 SELECTED_OUT |-> OUTPUT_FLOAT_OUT)
        else $error("outputs not floated on first cycle");

    // Float and hold behaviour
    a_float_deselect: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R12
        !SELECTED_OUT |-> OUTPUT_FLOAT_OUT)
        else $error("outputs not floated while deselected");
    a_float_write: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R12
        LANE_WRITE_OUT != '0 |-> OUTPUT_FLOAT_OUT)
        else $error("outputs not floated on write");
    a_read_drives: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R12
        READ_GO_OUT && $past(SELECTED_OUT) |-> !OUTPUT_FLOAT_OUT)
        else $error("outputs floated on a selected read");
    a_step_deselected: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R04
        edge_ok && BURST_STEP_OR_FETCH_IN && !SELECTED_OUT
        |=> !SELECTED_OUT && LANE_WRITE_OUT == '0 && !READ_GO_OUT)
        else $error("step acted while deselected");
    a_hold_access: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN) // see R10
        CLOCK_QUALIFY_N_IN |=> !READ_GO_OUT && $stable(ACCESS_ADDR_OUT))
        else $error("qualify high started an access");

    // Main scenarios
    c_write_burst: cover property (@(posedge CLK_IN) do_load && !WRITE_STROBE_N_IN ##1 do_step);
    c_read_burst: cover property (@(posedge CLK_IN) do_load && WRITE_STROBE_N_IN ##1 do_step);
    c_suspend: cover property (@(posedge CLK_IN) SELECTED_OUT && CLOCK_QUALIFY_N_IN [*3]);
    c_deselect: cover property (@(posedge CLK_IN) SELECTED_OUT ##1 !SELECTED_OUT);
    c_interleave_step: cover property (@(posedge CLK_IN) do_step && order_r);
endmodule

// File: ssic_ctrl_model.sv
`timescale 1ns/100ps
module ssic_ctrl_model (
    input  wire logic   clk_in,     // Clock
    output logic [19:0] addr_out,   // Address
    output logic [3:0]  lane_n_out, // Lane selects, low active
    output logic        we_n_out,   // Write strobe, low active
    output logic        fetch_out,  // High step, low load
    output logic        qual_n_out, // Clock qualify, low active
    output logic [2:0]  cs_out      // Selects one_n, two, three_n
);
    initial {addr_out, lane_n_out, we_n_out, fetch_out, qual_n_out, cs_out} = {24'h0, 6'h3F};
    // Kinds: 0 load write, 1 load read, 2 step, 3 deselect, 4 stalled edge
    task put(input int k, input logic [19:0] a, input logic [3:0] l, input logic [2:0] c);
        @(posedge clk_in);
        qual_n_out <= (k == 4);
        fetch_out  <= (k == 2);
        we_n_out   <= (k == 2) ? we_n_out : (k != 0);
        lane_n_out <= l;
        cs_out     <= (k == 3) ? c : 3'h2;
        // Address is a don't care on steps and deselects, so scramble it
        addr_out   <= (k == 2 || k == 3) ? ~addr_out : a;
    endtask
endmodule

// File: sync_sram_input_control_test.sv
`timescale 1ns/100ps
module sync_sram_input_control_test;
    logic        clk = 0, rst_n = 0, order = 1, ex_rd, ex_sel, fl_chk, first, sel, is_wr;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  par = 4'h0, ex_lw, lane_n, lw;
    logic [19:0] base, ex_addr, addr, acc;
    logic [35:0] ex_wd, wd;
    logic [2:0]  cs, dsl [3] = '{3'h6, 3'h0, 3'h3};
    logic [1:0]  cnt;
    logic        we_n, fetch, qual_n, rd, seld, fl;
    int          errors = 0, n_checks = 0, seed = 21;
    always #5 clk = ~clk;
    ssic_ctrl_model ctrl (.clk_in(clk), .addr_out(addr), .lane_n_out(lane_n), .we_n_out(we_n),
        .fetch_out(fetch), .qual_n_out(qual_n), .cs_out(cs));
    ssic_top dut (.CLK_IN(clk), .RESETN_IN(rst_n), .ADDRESS_IN(addr),
        .BYTE_LANE_WRITE_SEL_N_IN(lane_n), .WRITE_STROBE_N_IN(we_n),
        .BURST_STEP_OR_FETCH_IN(fetch), .CLOCK_QUALIFY_N_IN(qual_n),
        .CHIP_SELECT_ONE_N_IN(cs[2]), .CHIP_SELECT_TWO_IN(cs[1]), .CHIP_SELECT_THREE_N_IN(cs[0]),
        .BURST_ORDER_IN(order), .WRITE_DATA_IN(wdata), .PARITY_LANE_IN(par),
        .ACCESS_ADDR_OUT(acc), .LANE_WRITE_OUT(lw), .ARRAY_WDATA_OUT(wd), .READ_GO_OUT(rd),
        .SELECTED_OUT(seld), .OUTPUT_FLOAT_OUT(fl));
    task report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function logic [1:0] burst(input logic [1:0] b, input logic [1:0] n, input logic o);
        return o ? b ^ n : b + n;
    endfunction
    // Issue one request, then check the outcome of the previous one
    task op(input int k, input logic [19:0] a, input logic [3:0] l, input logic [2:0] c);
        ctrl.put(k, a, l, c);
        wdata <= $random(seed);
        par   <= 4'($random(seed));
        #1;
        chk(36'(lw), 36'(ex_lw));
        chk(36'(rd), 36'(ex_rd));
        chk(36'(seld), 36'(ex_sel));
        if (ex_sel) chk(36'(acc), 36'(ex_addr));
        chk(36'(fl), 36'(fl_chk));
        if (ex_lw != 4'h0) chk(wd, ex_wd);
        if (k != 4) begin
            if (k < 2) begin
                base = a;
                cnt = 2'h0;
                is_wr = (k == 0);
                sel = 1'b1;
            end
            if (k == 2 && sel) cnt++;
            if (k == 3) sel = 1'b0;
            fl_chk = !sel || (is_wr && k < 3) || (k < 2 && first);
            first = (k == 3) || (first && k == 2);
            ex_lw = (sel && k < 3 && is_wr) ? ~l : 4'h0;
            ex_rd = sel && k < 3 && !is_wr;
            ex_sel = sel;
            ex_addr = {base[19:2], burst(base[1:0], cnt, order)};
            for (int g = 0; g < 4; g++) ex_wd[g*9+:9] = {par[g], wdata[g*8+:8]};
        end else begin
            ex_lw = 4'h0;
            ex_rd = 1'b0;
        end
    endtask
    initial begin
        #20000;
        errors++;
        report_and_stop;
    end
    initial begin
        for (int o = 1; o >= 0; o--) begin
            ctrl.put(4, 20'h0, 4'hF, 3'h0);
            rst_n <= 1'b0;
            order <= o[0];
            repeat (8) @(posedge clk);
            rst_n <= 1'b1;
            {sel, first, ex_lw, ex_rd, ex_sel, fl_chk, is_wr} = {2'b01, 6'h0, 2'b10};
            op(4, 20'h0, 4'h0, 3'h0);
            op(4, 20'h0, 4'h0, 3'h0);
            op(0, 20'hFFFFE, 4'h0, 3'h0);
            repeat (4) op(2, 20'h0, 4'hA, 3'h0);
            op(4, 20'h12345, 4'h0, 3'h0);
            op(2, 20'h0, 4'h5, 3'h0);
            op(1, 20'hABCD3, 4'h0, 3'h0);
            op(2, 20'h0, 4'h0, 3'h0);
            for (int i = 0; i < 3; i++) begin
                op(3, 20'h0, 4'h0, dsl[i]);
                op(2, 20'h0, 4'h0, 3'h0);
                op(i % 2, 20'($random(seed)), 4'($random(seed)), 3'h0);
            end
            repeat (150) op($unsigned($random(seed)) % 5, 20'($random(seed)),
                4'($random(seed)), dsl[$unsigned($random(seed)) % 3]);
            op(4, 20'h0, 4'h0, 3'h0);
        end
        report_and_stop;
    end
endmodule
